// ---- rtl/fbr_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbr_pin_sync
  import fbr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= PIN_RST_LEVEL;
      s2_r <= PIN_RST_LEVEL;
      s3_r <= PIN_RST_LEVEL;
      level_r <= PIN_RST_LEVEL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level = level_r;
endmodule : fbr_pin_sync
`default_nettype wire

// ---- rtl/fbr_pkg.sv ----
package fbr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int POR_WAIT_US = 400;
  localparam int COPY_US = 70;
  localparam int RESET_NS = 1000;
  localparam int INT_LOW_MAX_NS = 200;
  localparam int POR_WAIT_CYC = POR_WAIT_US * CLK_MHZ;
  localparam int COPY_CYC = COPY_US * CLK_MHZ;
  localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int INT_LOW_MAX_CYC = (INT_LOW_MAX_NS * CLK_MHZ) / 1000;
  localparam int TMR_W = 17;
  localparam logic [TMR_W-1:0] TMR_RST = 17'h00000;

  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [15:0] IDX_BOOT_MAIN_LAST = 16'h01ff;
  localparam logic [15:0] IDX_BOOT_SPARE_FIRST = 16'h8000;
  localparam logic [15:0] IDX_BOOT_SPARE_LAST = 16'h800f;
  localparam logic [15:0] IDX_DATA_FIRST = 16'h0400;
  localparam logic [15:0] IDX_DATA_LAST = 16'h07ff;
  localparam logic [15:0] IDX_START_ADDR = 16'hf100;
  localparam logic [15:0] IDX_COMMAND = 16'hf220;
  localparam logic [15:0] IDX_SYS_CFG = 16'hf221;
  localparam logic [15:0] IDX_STATUS = 16'hf240;
  localparam logic [15:0] IDX_INT_STATUS = 16'hf241;

  // ==========================================================
  // buffer layout and copy lengths
  localparam int MEM_DEPTH = 2048;
  localparam logic [10:0] LOC_SPARE_BASE = 11'h200;
  localparam logic [10:0] LOC_DATA_BASE = 11'h400;
  localparam logic [10:0] BOOT_WORDS = 11'h210;
  localparam logic [10:0] LOAD_WORDS = 11'h400;

  // ==========================================================
  // commands
  localparam logic [15:0] CMD_LOAD = 16'h0000;
  localparam logic [15:0] CMD_PROGRAM = 16'h0080;
  localparam logic [15:0] CMD_ERASE = 16'h0094;
  localparam logic [15:0] CMD_RST_BOOT = 16'h00f0;
  localparam logic [15:0] CMD_RST_REG = 16'h00f3;

  // ==========================================================
  // fields and reset values
  localparam int CFG_AUTO = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_OE = 2;
  localparam logic [2:0] CFG_RST = 3'h6;
  localparam int INT_BIT = 15;
  localparam int STS_BUSY = 15;
  localparam int STS_LOCK = 1;
  localparam int STS_COPIED = 0;
  localparam logic PIN_RST_LEVEL = 1'h0;
  localparam logic [15:0] START_RST = 16'h0000;
  localparam logic [15:0] CMD_REG_RST = 16'h0000;

  typedef enum logic [6:0] {
    ST_POR_WAIT = 7'h01,
    ST_COPY = 7'h02,
    ST_PIN_WAIT = 7'h04,
    ST_RESETTING = 7'h08,
    ST_READY = 7'h10,
    ST_BUSY = 7'h20,
    ST_LOAD = 7'h40
  } fbr_state_t;

  typedef struct packed {
    logic [15:0] idx;
    logic wr;
    logic mapped;
    logic in_mem;
    logic in_boot;
    logic [10:0] loc;
  } fbr_aphase_t;

endpackage : fbr_pkg

// ---- rtl/fbr_seq.sv ----
// Function
// - after power-on, wait 400 us before the boot copy starts.
// - boot copy moves 1K bytes of block zero, about 70 us; reads valid after.
// - cold reset completion rises once copy is done and reset pin is high.
// - after warm reset only boot buffer reads are served until completion is ready.
// - warm or hot reset reinitialises registers but keeps buffer contents.
// - command 00F0h resets the boot partition, 00F3h resets via command register.
// - boot partition is indices 0000h-01FFh and 8000h-800Fh.
// - auto mode: device clears the interrupt bit right after a command.
// - auto mode: completion goes low within 200 ns of the command.
// - finished program, erase or load sets completion high again.
// - output enable and polarity settings, both default one, shape the pin.
// - completion pin is push-pull, always driven while enabled.
// - status reads are served while load, program or erase runs.
// - only 1KB copied at boot; more code loads into a 2KB data buffer.
`timescale 1ns/1ps
`default_nettype none
module fbr_seq
  import fbr_pkg::*;
#(
  parameter int POR_WAIT_CYCLES = POR_WAIT_CYC,
  parameter int COPY_CYCLES = COPY_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic hard_reset_pin_n,
  output logic completion_pin_o,
  output logic completion_pin_oe,
  output logic flash_rd_en,
  output logic [26:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic [15:0] flash_rd_data,
  output logic flash_op_start,
  output logic [15:0] flash_op_code,
  input wire logic flash_op_done
);
  localparam int AUTO_LOW_MAX = INT_LOW_MAX_CYC;

  // ==========================================================
  // declarations
  fbr_state_t state_r, state_nxt;
  fbr_aphase_t dec, aph_r;
  logic act_r;
  logic [31:0] hrdata_r;
  logic [15:0] rd_val;
  logic [15:0] mem [MEM_DEPTH];
  logic mem_we;
  logic [10:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic pin_level;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_value;
  logic tmr_expired;
  logic por_armed_r;
  logic copy_done_r;
  logic boot_lock_r;
  logic int_bit_r;
  logic [2:0] cfg_r;
  logic [15:0] start_r;
  logic [15:0] cmd_r;
  logic pin_o_r;
  logic pin_oe_r;
  logic eng_active_r;
  logic eng_wait_r;
  logic [10:0] eng_len_r;
  logic [10:0] eng_req_r;
  logic [10:0] eng_got_r;
  logic [10:0] eng_base_r;
  logic [15:0] eng_src_r;
  logic eng_boot;
  logic eng_load;
  logic rd_en_r;
  logic [26:0] rd_addr_r;
  logic op_start_r;
  logic [15:0] op_code_r;
  logic [15:0] wdata;
  logic wr_act;
  logic reg_wr;
  logic cmd_accept;
  logic is_rst_cmd;
  logic go_reset;
  logic ready_evt;
  int por_cnt_r;

  fbr_pin_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(hard_reset_pin_n),
    .level(pin_level)
  );

  fbr_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(tmr_load),
    .value(tmr_value),
    .expired(tmr_expired)
  );

  // ==========================================================
  // ahb-lite slave: one wait state, data comes from a register
  always_comb begin
    dec = '0;
    dec.idx = haddr[17:2];
    dec.wr = hwrite;
    if (haddr[31:18] == 14'h0000) begin
      dec.mapped = 1'b1;
      if (dec.idx <= IDX_BOOT_MAIN_LAST) begin
        dec.in_mem = 1'b1;
        dec.in_boot = 1'b1;
        dec.loc = dec.idx[10:0];
      end else if (dec.idx >= IDX_BOOT_SPARE_FIRST && dec.idx <= IDX_BOOT_SPARE_LAST) begin
        dec.in_mem = 1'b1;
        dec.in_boot = 1'b1;
        dec.loc = LOC_SPARE_BASE | {7'h00, dec.idx[3:0]};
      end else if (dec.idx >= IDX_DATA_FIRST && dec.idx <= IDX_DATA_LAST) begin
        dec.in_mem = 1'b1;
        dec.loc = dec.idx[10:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_r <= 1'b0;
      aph_r <= '0;
    end else begin
      act_r <= hsel && hready && htrans[1];
      if (hsel && hready && htrans[1]) begin
        aph_r <= dec;
      end
    end
  end

  assign hreadyout = ~act_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign wdata = hwdata[15:0];
  // while locked every write is dropped
  assign wr_act = act_r && aph_r.wr && aph_r.mapped && !boot_lock_r;
  assign reg_wr = wr_act && !aph_r.in_mem;
  assign cmd_accept = reg_wr && aph_r.idx == IDX_COMMAND && state_r == ST_READY;
  assign is_rst_cmd = wdata == CMD_RST_BOOT || wdata == CMD_RST_REG;

  always_comb begin
    rd_val = 16'h0000;
    if (boot_lock_r) begin
      if (aph_r.in_boot && copy_done_r) begin
        rd_val = mem[aph_r.loc];
      end
    end else if (aph_r.in_mem) begin
      rd_val = mem[aph_r.loc];
    end else if (aph_r.mapped) begin
      unique case (aph_r.idx)
        IDX_START_ADDR: rd_val = start_r;
        IDX_COMMAND: rd_val = cmd_r;
        IDX_SYS_CFG: rd_val = {13'h0000, cfg_r};
        IDX_STATUS: begin
          rd_val[STS_BUSY] = state_r == ST_BUSY || state_r == ST_LOAD;
          rd_val[STS_LOCK] = boot_lock_r;
          rd_val[STS_COPIED] = copy_done_r;
        end
        IDX_INT_STATUS: rd_val[INT_BIT] = int_bit_r;
        default: rd_val = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (act_r && !aph_r.wr) begin
      hrdata_r <= {16'h0000, rd_val};
    end
  end

  // ==========================================================
  // sequencer
  assign go_reset = (state_r == ST_READY || state_r == ST_BUSY || state_r == ST_LOAD)
                    && (!pin_level || (cmd_accept && is_rst_cmd));
  assign ready_evt = state_nxt == ST_READY && state_r != ST_READY;

  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_value = TMR_RST;
    eng_boot = 1'b0;
    eng_load = 1'b0;
    if (go_reset) begin
      state_nxt = ST_RESETTING;
      tmr_load = 1'b1;
      tmr_value = TMR_W'(RESET_CYC);
    end else begin
      unique case (state_r)
        ST_POR_WAIT: begin
          if (!por_armed_r) begin
            tmr_load = 1'b1;
            tmr_value = TMR_W'(POR_WAIT_CYCLES);
          end else if (tmr_expired) begin
            state_nxt = ST_COPY;
            tmr_load = 1'b1;
            tmr_value = TMR_W'(COPY_CYCLES);
            eng_boot = 1'b1;
          end
        end
        ST_COPY: if (!eng_active_r && tmr_expired) state_nxt = ST_PIN_WAIT;
        ST_PIN_WAIT: if (pin_level) state_nxt = ST_READY;
        ST_RESETTING: begin
          if (!pin_level) begin
            tmr_load = 1'b1;
            tmr_value = TMR_W'(RESET_CYC);
          end else if (tmr_expired) begin
            state_nxt = ST_READY;
          end
        end
        ST_READY: begin
          if (cmd_accept && wdata == CMD_LOAD) begin
            state_nxt = ST_LOAD;
            eng_load = 1'b1;
          end else if (cmd_accept && (wdata == CMD_PROGRAM || wdata == CMD_ERASE)) begin
            state_nxt = ST_BUSY;
          end
        end
        ST_BUSY: if (flash_op_done) state_nxt = ST_READY;
        ST_LOAD: if (!eng_active_r) state_nxt = ST_READY;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_POR_WAIT;
      por_armed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_POR_WAIT) begin
        por_armed_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      copy_done_r <= 1'b0;
      boot_lock_r <= 1'b1;
    end else begin
      if (state_r == ST_COPY && state_nxt == ST_PIN_WAIT) begin
        copy_done_r <= 1'b1;
      end
      // register reset leaves the lock open, pin and boot reset close it
      if (go_reset && (!pin_level || wdata == CMD_RST_BOOT)) begin
        boot_lock_r <= 1'b1;
      end else if (ready_evt) begin
        boot_lock_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software registers, reinitialised by warm and hot reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= CFG_RST;
      start_r <= START_RST;
      cmd_r <= CMD_REG_RST;
    end else if (go_reset) begin
      cfg_r <= CFG_RST;
      start_r <= START_RST;
      cmd_r <= CMD_REG_RST;
    end else if (reg_wr) begin
      if (aph_r.idx == IDX_SYS_CFG) cfg_r <= wdata[2:0];
      if (aph_r.idx == IDX_START_ADDR) start_r <= wdata;
      if (cmd_accept) cmd_r <= wdata;
    end
  end

  // reset clear wins over set, set wins over the auto and write clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_bit_r <= 1'b0;
    end else if (go_reset) begin
      int_bit_r <= 1'b0;
    end else if (ready_evt) begin
      int_bit_r <= 1'b1;
    end else if (cmd_accept && cfg_r[CFG_AUTO]) begin
      int_bit_r <= 1'b0;
    end else if (reg_wr && aph_r.idx == IDX_INT_STATUS) begin
      int_bit_r <= wdata[INT_BIT];
    end
  end

  // push-pull: driven at both levels whenever enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o_r <= ~CFG_RST[CFG_POL];
      pin_oe_r <= CFG_RST[CFG_OE];
    end else begin
      pin_o_r <= cfg_r[CFG_POL] ? int_bit_r : ~int_bit_r;
      pin_oe_r <= cfg_r[CFG_OE];
    end
  end

  assign completion_pin_o = pin_o_r;
  assign completion_pin_oe = pin_oe_r;

  // ==========================================================
  // copy engine: one flash read outstanding at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_active_r <= 1'b0;
      eng_wait_r <= 1'b0;
      eng_len_r <= 11'h000;
      eng_req_r <= 11'h000;
      eng_got_r <= 11'h000;
      eng_base_r <= 11'h000;
      eng_src_r <= 16'h0000;
      rd_en_r <= 1'b0;
      rd_addr_r <= 27'h0000000;
    end else begin
      rd_en_r <= 1'b0;
      if (eng_boot || eng_load) begin
        eng_active_r <= 1'b1;
        eng_wait_r <= 1'b0;
        eng_req_r <= 11'h000;
        eng_got_r <= 11'h000;
        eng_len_r <= eng_boot ? BOOT_WORDS : LOAD_WORDS;
        eng_base_r <= eng_boot ? 11'h000 : LOC_DATA_BASE;
        eng_src_r <= eng_boot ? 16'h0000 : start_r;
      end else if (go_reset) begin
        eng_active_r <= 1'b0;
      end else if (eng_active_r) begin
        if (!eng_wait_r && eng_req_r != eng_len_r) begin
          rd_en_r <= 1'b1;
          rd_addr_r <= {eng_src_r, eng_req_r};
          eng_req_r <= eng_req_r + 11'h001;
          eng_wait_r <= 1'b1;
        end
        if (flash_rd_valid && eng_wait_r) begin
          eng_wait_r <= 1'b0;
          eng_got_r <= eng_got_r + 11'h001;
          if (eng_got_r + 11'h001 == eng_len_r) begin
            eng_active_r <= 1'b0;
          end
        end
      end
    end
  end

  assign flash_rd_en = rd_en_r;
  assign flash_rd_addr = rd_addr_r;

  // buffer memory has no reset, so no reset ever disturbs it
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = aph_r.loc;
    mem_wdata = wdata;
    if (eng_active_r && eng_wait_r && flash_rd_valid) begin
      mem_we = 1'b1;
      mem_waddr = eng_base_r + eng_got_r;
      mem_wdata = flash_rd_data;
    end else if (wr_act && aph_r.in_mem && state_r != ST_LOAD) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_start_r <= 1'b0;
      op_code_r <= 16'h0000;
    end else begin
      op_start_r <= cmd_accept && (wdata == CMD_PROGRAM || wdata == CMD_ERASE);
      if (cmd_accept) op_code_r <= wdata;
    end
  end

  assign flash_op_start = op_start_r;
  assign flash_op_code = op_code_r;

  // ==========================================================
  // checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) por_cnt_r <= 0;
    else if (state_r == ST_POR_WAIT) por_cnt_r <= por_cnt_r + 1;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_por_wait_time: assert property (
    (state_r == ST_POR_WAIT && state_nxt == ST_COPY) |-> por_cnt_r >= POR_WAIT_CYCLES
  ) else $error("boot copy started before the power-on wait");

  a_copy_words: assert property (
    (state_r == ST_COPY && state_nxt == ST_PIN_WAIT) |-> eng_got_r == BOOT_WORDS && tmr_expired
  ) else $error("boot copy ended early");

  a_cold_int_rise: assert property (
    $rose(int_bit_r) |-> $past(pin_level) && copy_done_r
  ) else $error("completion rose without copy done and reset pin high");

  a_pin_wait_ready: assert property (
    (state_r == ST_PIN_WAIT && pin_level) |=> int_bit_r && !boot_lock_r
  ) else $error("completion not raised after reset pin release");

  a_lock_blocks_write: assert property (
    (act_r && aph_r.wr && boot_lock_r) |=> $stable(cfg_r) && $stable(start_r) && state_r != ST_BUSY
  ) else $error("write accepted while boot lock held");

  a_reset_keeps_buf: assert property (
    (state_r == ST_RESETTING) |-> !mem_we
  ) else $error("buffer written during internal reset");

  a_reset_cmd: assert property (
    (cmd_accept && is_rst_cmd && pin_level) |=> state_r == ST_RESETTING && !int_bit_r && cfg_r == CFG_RST
  ) else $error("reset command did not reset");

  a_boot_map: assert property (
    (act_r && aph_r.mapped && (aph_r.idx <= IDX_BOOT_MAIN_LAST
      || (aph_r.idx >= IDX_BOOT_SPARE_FIRST && aph_r.idx <= IDX_BOOT_SPARE_LAST))) |-> aph_r.in_boot
  ) else $error("boot partition index not decoded");

  a_auto_clear: assert property (
    (cmd_accept && cfg_r[CFG_AUTO] && !is_rst_cmd && wdata != CMD_LOAD) |=> !int_bit_r
  ) else $error("auto mode did not clear interrupt bit");

  a_auto_pin_low: assert property (
    (cmd_accept && cfg_r[CFG_AUTO] && cfg_r[CFG_POL] && cfg_r[CFG_OE] && pin_level
      && (wdata == CMD_PROGRAM || wdata == CMD_ERASE))
      |-> ##[1:AUTO_LOW_MAX] (!completion_pin_o && completion_pin_oe)
  ) else $error("completion pin not low in time");

  a_done_sets_int: assert property (
    (state_r == ST_BUSY && flash_op_done && pin_level) |=> int_bit_r ##1 completion_pin_o == cfg_r[CFG_POL]
  ) else $error("operation end did not set completion");

  a_pin_polarity: assert property (
    (!cfg_r[CFG_POL] && cfg_r[CFG_OE] && int_bit_r) [*2] |-> !completion_pin_o && completion_pin_oe
  ) else $error("completion polarity wrong");

  a_status_busy: assert property (
    (act_r && !aph_r.wr && !boot_lock_r && aph_r.idx == IDX_STATUS && !aph_r.in_mem
      && (state_r == ST_BUSY || state_r == ST_LOAD)) |=> hrdata[STS_BUSY] && hreadyout
  ) else $error("status read during operation not served");

  a_load_words: assert property (
    (state_r == ST_LOAD && state_nxt == ST_READY) |-> eng_got_r == LOAD_WORDS
  ) else $error("load ended with wrong word count");

endmodule : fbr_seq
`default_nettype wire

// ---- rtl/fbr_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbr_timer
  import fbr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [TMR_W-1:0] value,
  output logic expired
);
  logic [TMR_W-1:0] cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= TMR_RST;
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != TMR_RST) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = (cnt_r == TMR_RST);
endmodule : fbr_timer
`default_nettype wire

// ---- tb/fbr_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbr_flash_model #(
  parameter int OP_CYC = 30
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic flash_rd_en,
  input wire logic [26:0] flash_rd_addr,
  output logic flash_rd_valid,
  output logic [15:0] flash_rd_data,
  input wire logic flash_op_start,
  output logic flash_op_done
);
  // ==========================================================
  // array core: read answers 1..4 cycles after the request is sampled, wait taken from the address, so both prompt and slow answers occur
  logic rd_busy;
  logic [1:0] rd_wait;
  logic [15:0] op_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_busy <= 1'b0;
      rd_wait <= 2'h0;
      flash_rd_valid <= 1'b0;
      flash_rd_data <= 16'h0000;
    end else begin
      flash_rd_valid <= 1'b0;
      // data lines toggle every cycle between answers, so the last word shows again every second cycle
      flash_rd_data <= ~flash_rd_data;
      if (flash_rd_en) begin
        rd_busy <= 1'b1;
        rd_wait <= flash_rd_addr[1:0];
      end else if (rd_busy && rd_wait != 2'h0) begin
        rd_wait <= rd_wait - 2'h1;
      end else if (rd_busy) begin
        rd_busy <= 1'b0;
        flash_rd_valid <= 1'b1;
        flash_rd_data <= flash_rd_addr[15:0] ^ {flash_rd_addr[26:16], 5'h00} ^ 16'h5a3c;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_cnt <= 16'h0000;
      flash_op_done <= 1'b0;
    end else begin
      flash_op_done <= (op_cnt == 16'h0001);
      if (flash_op_start) begin
        op_cnt <= 16'(OP_CYC);
      end else if (op_cnt != 16'h0000) begin
        op_cnt <= op_cnt - 16'h0001;
      end
    end
  end
endmodule : fbr_flash_model
`default_nettype wire

// ---- tb/flash_boot_reset_and_done_signal_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_boot_reset_and_done_signal_bench;
  import fbr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hard_reset_pin_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, pin_o, pin_oe, rd_en, rd_valid, op_start, op_done, rdy_s, pin_s, oe_s;
  logic [31:0] hrdata;
  logic [26:0] rd_addr;
  logic [15:0] rd_data, op_code, rd_s, rv, st, n, cmd;
  logic [31:0] seed = 32'd13692;
  int fail_count = 0;
  int checks_done = 0;
  always #2 hclk = ~hclk;
  // sampled mid-cycle so the value equals what the next rising edge sees
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata[15:0];
    pin_s = pin_o;
    oe_s = pin_oe;
  end
  fbr_seq #(.POR_WAIT_CYCLES(40), .COPY_CYCLES(600)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hard_reset_pin_n(hard_reset_pin_n),
    .completion_pin_o(pin_o), .completion_pin_oe(pin_oe), .flash_rd_en(rd_en), .flash_rd_addr(rd_addr),
    .flash_rd_valid(rd_valid), .flash_rd_data(rd_data), .flash_op_start(op_start), .flash_op_code(op_code),
    .flash_op_done(op_done));
  fbr_flash_model FM (.hclk(hclk), .hresetn(hresetn), .flash_rd_en(rd_en), .flash_rd_addr(rd_addr),
    .flash_rd_valid(rd_valid), .flash_rd_data(rd_data), .flash_op_start(op_start), .flash_op_done(op_done));
  // ==========================================================
  // helpers
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : xs
  function automatic logic [15:0] exp_word(input logic [26:0] a);
    return a[15:0] ^ {a[26:16], 5'h00} ^ 16'h5a3c;
  endfunction : exp_word
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic wait_pin(input logic lvl, input int bound);
    int k;
    k = 0;
    while (pin_s !== lvl && k < bound) begin
      @(posedge hclk);
      k++;
    end
    chk_pin(pin_s, lvl);
    if (pin_s !== lvl) end_sim();
  endtask : wait_pin
  task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] wd);
    int k;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    k = 0;
    do begin @(posedge hclk); k++; end while (rdy_s !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    do begin @(posedge hclk); k++; end while (rdy_s !== 1'b1 && k < 100);
    rv = rd_s;
    if (k >= 100) begin
      fail_count++;
      end_sim();
    end
  endtask : bus
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 16'h0000, 16'h0);
    chk_reg(rv, 16'h0000);
    repeat (3000) @(posedge hclk);
    chk_pin(pin_s, 1'b0);
    hard_reset_pin_n <= 1'b1;
    wait_pin(1'b1, 20);
    for (int i = 0; i < 8; i++) begin
      n = (i == 0) ? 16'd511 : (i == 1) ? 16'd527 : xs() % 16'd528;
      bus(1'b0, (n < 16'd512) ? n : IDX_BOOT_SPARE_FIRST + n - 16'd512, 16'h0);
      chk_reg(rv, exp_word({16'h0, n[10:0]}));
    end
    bus(1'b0, 16'h1234, 16'h0);
    chk_reg(rv, 16'h0000);
    $display("cold reset and boot copy done");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, IDX_SYS_CFG, 16'(c));
      repeat (2) @(posedge hclk);
      chk_pin(oe_s, 1'(c >> 2));
      chk_pin(pin_s, 1'(c >> 1));
    end
    for (int i = 0; i < 4; i++) begin
      cmd = i[0] ? CMD_ERASE : CMD_PROGRAM;
      bus(1'b1, IDX_SYS_CFG, {15'h0003, i[1]});
      if (!i[1]) bus(1'b1, IDX_INT_STATUS, 16'h0);
      bus(1'b1, IDX_COMMAND, cmd);
      bus(1'b0, IDX_INT_STATUS, 16'h0);
      chk_reg(rv, 16'h0000);
      bus(1'b0, IDX_STATUS, 16'h0);
      chk_reg(rv, 16'h8001);
      chk_pin(hresp, 1'b0);
      chk_reg(op_code, cmd);
      wait_pin(1'b0, 50);
      wait_pin(1'b1, 200);
      // keep the gap after completion before the next IDX_SYS_CFG or IDX_START_ADDR write
      repeat (30) @(posedge hclk);
    end
    st = xs();
    bus(1'b1, IDX_START_ADDR, st);
    bus(1'b1, IDX_INT_STATUS, 16'h0);
    bus(1'b1, IDX_COMMAND, CMD_LOAD);
    wait_pin(1'b1, 8000);
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 16'd1023 : xs() % 16'd1024;
      bus(1'b0, IDX_DATA_FIRST + n, 16'h0);
      chk_reg(rv, exp_word({st, n[10:0]}));
    end
    $display("commands and load done");
    hard_reset_pin_n <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(1'b1, IDX_SYS_CFG, 16'h0001);
    bus(1'b0, IDX_DATA_FIRST + n, 16'h0);
    chk_reg(rv, 16'h0000);
    bus(1'b0, 16'h0000, 16'h0);
    chk_reg(rv, exp_word(27'h0));
    hard_reset_pin_n <= 1'b1;
    wait_pin(1'b1, 400);
    bus(1'b0, IDX_SYS_CFG, 16'h0);
    chk_reg(rv, {13'h0, CFG_RST});
    bus(1'b0, IDX_DATA_FIRST + n, 16'h0);
    chk_reg(rv, exp_word({st, n[10:0]}));
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, IDX_SYS_CFG, 16'h0007);
      bus(1'b1, IDX_COMMAND, i[0] ? CMD_RST_REG : CMD_RST_BOOT);
      wait_pin(1'b0, 50);
      wait_pin(1'b1, 400);
      bus(1'b0, IDX_SYS_CFG, 16'h0);
      chk_reg(rv, {13'h0, CFG_RST});
    end
    $display("warm and hot reset done");
    end_sim();
  end
endmodule : flash_boot_reset_and_done_signal_bench
`default_nettype wire
